// ---- inc/irq_prio_pkg.sv ----
package irq_prio_pkg;
    // Byte offsets on the register bus
    localparam logic [7:0] prio16_off      = 8'h00;
    localparam logic [7:0] prio17_off      = 8'h04;
    localparam logic [7:0] prio18_off      = 8'h08;
    localparam logic [7:0] prio19_off      = 8'h0c;
    localparam logic [7:0] level_vec_off   = 8'h10;
    localparam logic [7:0] flag_off        = 8'h14;
    localparam logic [7:0] enable_off      = 8'h18;
    localparam logic [7:0] control_one_off = 8'h1c;
    localparam logic [7:0] cpu_ctrl_off    = 8'h20;
    localparam logic [7:0] evt_status_off  = 8'h24;
    localparam logic [7:0] evt_clear_off   = 8'h28;
    localparam logic [7:0] evt_enable_off  = 8'h2c;

    // Sources, in natural vector order
    localparam int num_src = 11;
    localparam int num_trap = 4;

    // Field positions (low bit of each 3-bit field)
    localparam int crc_err_lsb     = 12;
    localparam int serial2_err_lsb = 8;
    localparam int serial1_err_lsb = 4;
    localparam int can_tx_lsb      = 8;
    localparam int dma7_lsb        = 4;
    localparam int dma6_lsb        = 0;
    localparam int encoder2_lsb    = 12;
    localparam int pwm2_fault_lsb  = 8;
    localparam int pwm2_lsb        = 4;
    localparam int dac_left_lsb    = 12;
    localparam int dac_right_lsb   = 8;

    // Writable masks of the priority registers
    localparam logic [15:0] prio16_mask = 16'h7770;
    localparam logic [15:0] prio17_mask = 16'h0777;
    localparam logic [15:0] prio18_mask = 16'h7770;
    localparam logic [15:0] prio19_mask = 16'h7700;

    // Reset values: level 4 except the pwm2 fault and dac right fields
    localparam logic [15:0] prio16_rst = 16'h4440;
    localparam logic [15:0] prio17_rst = 16'h0444;
    localparam logic [15:0] prio18_rst = 16'h4040;
    localparam logic [15:0] prio19_rst = 16'h4000;

    // Status register fields and the nesting disable bit of control one
    localparam int level_lsb   = 8;
    localparam int vector_lsb  = 0;
    localparam int nest_dis_bit = 15;

    // Vector codes: traps first, then user sources
    localparam logic [6:0] src_vec_base = 7'h08;
    localparam logic [3:0] trap_level_base = 4'h8;
    localparam logic [2:0] level_max_user = 3'h7;

    // Timed disable interval
    localparam int disable_time_ns = 1000;
    localparam int clk_period_ns   = 50;
    localparam int disable_cycles  = (disable_time_ns + clk_period_ns - 1) / clk_period_ns;

    // Event bits
    localparam int evt_take   = 0;
    localparam int evt_return = 1;
    localparam int num_evt    = 2;

    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_service = 2'b01,
        st_trap    = 2'b10
    } cpu_state_type;
endpackage : irq_prio_pkg

// ---- src/interrupt_priority_control.sv ----
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module interrupt_priority_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register bus
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hsel,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Source and trap events
    input  wire logic [irq_prio_pkg::num_src-1:0]  src_event,
    input  wire logic [irq_prio_pkg::num_trap-1:0] trap_event,
    // CPU handshake
    input  wire logic        irq_ack,
    input  wire logic        irq_return,
    input  wire logic        timed_disable,
    // Status to the CPU
    output logic             irq_req,
    output logic      [3:0]  irq_level,
    output logic      [6:0]  irq_vector,
    output logic      [3:0]  cpu_level,
    // Event interrupt
    output logic             irq_out
);
    import irq_prio_pkg::*;

    // Eleven user sources and
    // four traps compete for
    // the CPU. A user source
    // has a 3-bit level and is
    // off at level zero.
    // Traps sit at 8 to 11 and
    // pass every mask.
    // The winner is registered
    // each cycle, so level and
    // vector always agree.
    // Sources come from logic
    // on this clock and are
    // not synchronised.
    // Transfer size is ignored:
    // each register is a word.

    // All state of the block
    typedef struct packed {
        // Priority registers
        logic [15:0]         prio16;      // priority_reg_16
        logic [15:0]         prio17;      // priority_reg_17
        logic [15:0]         prio18;      // priority_reg_18
        logic [15:0]         prio19;      // priority_reg_19
        // Flags and enables
        logic [num_src-1:0]  flag;        // Source flags
        logic [num_src-1:0]  enable;      // Source enables
        logic                nest_dis;    // Nesting disable
        logic [num_trap-1:0] trap_flag;   // Trap status flags
        // CPU level tracking
        logic [3:0]          cpu_lvl;     // Current CPU level
        logic [3:0]          saved_lvl;   // Level before nesting
        logic [3:0]          lvl_stack;   // Level saved on take
        logic [15:0]         dis_cnt;     // Timed disable counter
        // Status snapshot
        logic [3:0]          new_lvl;     // Status level field
        logic [6:0]          vec;         // Status vector field
        logic                req;         // Pending request
        // Event interrupt
        logic [num_evt-1:0]  evt_stat;    // Sticky events
        logic [num_evt-1:0]  evt_en;      // Event enables
        // Bus data phase
        logic                ph_valid;    // Data phase pending
        logic                ph_write;    // Data phase is write
        logic [7:0]          ph_addr;     // Data phase address
        logic [31:0]         rdata;       // Read data
        // Service state
        cpu_state_type       state;       // Servicing state
    } state_type;

    // One register holds the
    // whole state, so reset
    // and the next-state copy
    // always stay in step.
    state_type s_r;   // Registered state
    state_type s_nxt; // Next state

    // Arbitration and bus helpers
    logic [2:0]  prio_f [num_src];   // Per-source priority
    logic [3:0]  best_lvl;           // Winning level
    logic [6:0]  best_vec;           // Winning vector code
    logic        best_hit;           // Any eligible source
    logic [3:0]  mask_lvl;           // Effective mask level
    logic [15:0] rd_mux;             // Read multiplexer
    logic [num_evt-1:0] evt_set;     // Event pulses

    // Index, register, code:
    //  0 crc error    16  4
    //  1 serial2 err  16  5
    //  2 serial1 err  16  6
    //  3 can transmit 17  7
    //  4 dma ch 7     17  8
    //  5 dma ch 6     17  9
    //  6 encoder 2    18 10
    //  7 pwm 2 fault  18 11
    //  8 pwm 2        18 12
    //  9 dac left     19 13
    // 10 dac right    19 14
    // Codes 0..3 are traps.
    // Field extraction for each source
    always_comb begin
        prio_f[0]  = s_r.prio16[crc_err_lsb+:3];
        prio_f[1]  = s_r.prio16[serial2_err_lsb+:3];
        prio_f[2]  = s_r.prio16[serial1_err_lsb+:3];
        prio_f[3]  = s_r.prio17[can_tx_lsb+:3];
        prio_f[4]  = s_r.prio17[dma7_lsb+:3];
        prio_f[5]  = s_r.prio17[dma6_lsb+:3];
        prio_f[6]  = s_r.prio18[encoder2_lsb+:3];
        prio_f[7]  = s_r.prio18[pwm2_fault_lsb+:3];
        prio_f[8]  = s_r.prio18[pwm2_lsb+:3];
        prio_f[9]  = s_r.prio19[dac_left_lsb+:3];
        prio_f[10] = s_r.prio19[dac_right_lsb+:3];
    end

    // Masks, weakest first:
    // CPU level; timed
    // disable (mask 6, so 7
    // still passes); nesting
    // disable in service
    // (mask 15, traps only).
    // A source must beat the
    // mask strictly, so CPU
    // level 7 stops all user
    // sources. Traps beat
    // users since they are
    // searched last. Result
    // is registered next edge.
    // Arbitration: traps first, then user sources by level
    always_comb begin
        best_hit = 1'b0;
        best_lvl = 4'h0;
        best_vec = 7'h00;

        // Timed disable raises the mask to 6, level 7 still passes
        mask_lvl = s_r.cpu_lvl;
        if (s_r.dis_cnt != 16'h0000 && s_r.cpu_lvl < 4'h6) begin
            mask_lvl = 4'h6;
        end

        // Nesting disabled: only traps preempt a running service
        if (s_r.nest_dis && s_r.state != st_idle) begin
            mask_lvl = 4'hf;
        end

        // Lowest index wins a tie since only a strictly higher level replaces
        for (int i = 0; i < num_src; i++) begin
            if (s_r.flag[i] && s_r.enable[i] && prio_f[i] != 3'h0 &&
                {1'b0, prio_f[i]} > mask_lvl && {1'b0, prio_f[i]} > best_lvl) begin
                best_hit = 1'b1;
                best_lvl = {1'b0, prio_f[i]};
                best_vec = 7'(i) + 7'(num_trap);
            end
        end

        // Traps ignore every mask, highest index highest level
        for (int t = 0; t < num_trap; t++) begin
            if (s_r.trap_flag[t]) begin
                best_hit = 1'b1;
                best_lvl = trap_level_base + 4'(t);
                best_vec = 7'(t);
            end
        end
    end

    // The address comes from
    // the registered address
    // phase, so the mux holds
    // still for the data phase.
    // Reserved bits read zero.
    // Event enable reads back;
    // event clear is write-only
    // and reads as zero.
    // Register read multiplexer
    always_comb begin
        rd_mux = 16'h0000;
        if (s_r.ph_addr == prio16_off) begin
            rd_mux = s_r.prio16;
        end else if (s_r.ph_addr == prio17_off) begin
            rd_mux = s_r.prio17;
        end else if (s_r.ph_addr == prio18_off) begin
            rd_mux = s_r.prio18;
        end else if (s_r.ph_addr == prio19_off) begin
            rd_mux = s_r.prio19;
        end else if (s_r.ph_addr == level_vec_off) begin
            rd_mux = {4'h0, s_r.new_lvl, 1'b0, s_r.vec};
        end else if (s_r.ph_addr == flag_off) begin
            rd_mux = 16'(s_r.flag);
        end else if (s_r.ph_addr == enable_off) begin
            rd_mux = 16'(s_r.enable);
        end else if (s_r.ph_addr == control_one_off) begin
            rd_mux = {s_r.nest_dis, 11'h000, s_r.trap_flag};
        end else if (s_r.ph_addr == cpu_ctrl_off) begin
            rd_mux = {12'h000, s_r.cpu_lvl};
        end else if (s_r.ph_addr == evt_status_off) begin
            rd_mux = 16'(s_r.evt_stat);
        end else if (s_r.ph_addr == evt_enable_off) begin
            rd_mux = 16'(s_r.evt_en);
        end else begin
            rd_mux = 16'h0000; // Unmapped reads zero
        end
    end

    // A take counts only when
    // a request stood; a
    // return counts only
    // inside a service.
    // Event pulses: interrupt taken and return
    assign evt_set = {irq_return && s_r.state != st_idle, irq_ack && s_r.req};

    // Steps in order: flag
    // events, disable count,
    // bus writes, stickiness,
    // address phase, status
    // snapshot, take/return.
    // Later steps win: a take
    // or return sets the CPU
    // level even if the bus
    // wrote it that cycle.
    // A flag write ORs in new
    // events, so set wins.
    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.ph_valid = 1'b0;
        // Hardware events set flags
        s_nxt.flag      = s_r.flag | src_event;
        s_nxt.trap_flag = s_r.trap_flag | trap_event;

        // Timed disable countdown
        if (timed_disable) begin
            s_nxt.dis_cnt = 16'(disable_cycles);
        end else if (s_r.dis_cnt != 16'h0000) begin
            s_nxt.dis_cnt = s_r.dis_cnt - 16'h0001;
        end

        // Data phase write
        if (s_r.ph_valid && s_r.ph_write) begin
            if (s_r.ph_addr == prio16_off) begin
                s_nxt.prio16 = hwdata[15:0] & prio16_mask;
            end else if (s_r.ph_addr == prio17_off) begin
                s_nxt.prio17 = hwdata[15:0] & prio17_mask;
            end else if (s_r.ph_addr == prio18_off) begin
                s_nxt.prio18 = hwdata[15:0] & prio18_mask;
            end else if (s_r.ph_addr == prio19_off) begin
                s_nxt.prio19 = hwdata[15:0] & prio19_mask;
            end else if (s_r.ph_addr == flag_off) begin
                // Software writes flags; new events still win
                s_nxt.flag = hwdata[num_src-1:0] | src_event;
            end else if (s_r.ph_addr == enable_off) begin
                s_nxt.enable = hwdata[num_src-1:0];
            end else if (s_r.ph_addr == control_one_off) begin
                s_nxt.nest_dis  = hwdata[nest_dis_bit];
                s_nxt.trap_flag = hwdata[num_trap-1:0] | trap_event;
            end else if (s_r.ph_addr == cpu_ctrl_off) begin
                s_nxt.cpu_lvl = hwdata[3:0];
            end else if (s_r.ph_addr == evt_clear_off) begin
                s_nxt.evt_stat = s_r.evt_stat & ~hwdata[num_evt-1:0];
            end else if (s_r.ph_addr == evt_enable_off) begin
                s_nxt.evt_en = hwdata[num_evt-1:0];
            end
        end

        // Sticky events: set wins over clear
        s_nxt.evt_stat = s_nxt.evt_stat | evt_set;

        // Address phase capture
        if (hsel && hready && htrans[1]) begin
            s_nxt.ph_valid = 1'b1;
            s_nxt.ph_write = hwrite;
            s_nxt.ph_addr  = haddr[7:0];
        end
        s_nxt.rdata = (s_r.ph_valid && !s_r.ph_write) ? {16'h0000, rd_mux} : s_r.rdata;

        // Status register tracks the winning request
        s_nxt.req     = best_hit;
        s_nxt.new_lvl = best_hit ? best_lvl : s_r.cpu_lvl;
        s_nxt.vec     = best_hit ? best_vec : 7'h00;

        // Two saved levels only:
        // deeper nesting loses
        // the oldest level, so
        // software nesting more
        // must keep its own.
        // Service sequencing
        case (s_r.state)
            st_idle, st_service, st_trap: begin
                if (irq_ack && s_r.req) begin
                    // Take: save current level and raise to the new one
                    s_nxt.lvl_stack = s_r.cpu_lvl;
                    s_nxt.saved_lvl = s_r.lvl_stack;
                    s_nxt.cpu_lvl   = s_r.new_lvl;
                    s_nxt.state     = (s_r.new_lvl >= trap_level_base) ? st_trap : st_service;
                end else if (irq_return && s_r.state != st_idle) begin
                    // Return restores the saved level; flags still set re-request
                    s_nxt.cpu_lvl   = s_r.lvl_stack;
                    s_nxt.lvl_stack = s_r.saved_lvl;
                    s_nxt.state     = (s_r.lvl_stack == 4'h0) ? st_idle : st_service;
                end
            end
            default: begin
                s_nxt.state = st_idle;
            end
        endcase
    end

    // Asynchronous reset sets
    // only constants: level 4
    // everywhere but pwm 2
    // fault and dac right,
    // which start disabled.
    // State register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r           <= '0;
            s_r.prio16    <= prio16_rst;
            s_r.prio17    <= prio17_rst;
            s_r.prio18    <= prio18_rst;
            s_r.prio19    <= prio19_rst;
            s_r.state     <= st_idle;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Writes take no wait
    // state; reads take one
    // while the mux result is
    // registered. hrdata then
    // holds until the next
    // read completes. The
    // response is always okay.
    // irq_out is high while an
    // enabled sticky event is set.
    // Outputs
    assign hrdata     = s_r.rdata;
    assign hreadyout  = !s_r.ph_valid || !s_r.ph_write ? !s_r.ph_valid : 1'b1;
    assign hresp      = 1'b0;
    assign irq_req    = s_r.req;
    assign irq_level  = s_r.new_lvl;
    assign irq_vector = s_r.vec;
    assign cpu_level  = s_r.cpu_lvl;
    assign irq_out    = |(s_r.evt_stat & s_r.evt_en);
endmodule : interrupt_priority_control

// ---- tb/interrupt_priority_control_sva.sv ----
`timescale 1ns/1ps
// Watches bus timing and request coding at the top ports
module interrupt_priority_control_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hsel,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       irq_ack,
    input wire logic       timed_disable,
    input wire logic       irq_req,
    input wire logic [3:0] irq_level,
    input wire logic [6:0] irq_vector,
    input wire logic [3:0] cpu_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic take; // Address phase accepted
    assign take = hsel && hready && htrans[1];
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_fast; take && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_no_zero; irq_req |-> irq_level != 4'h0; endproperty
    a_no_zero: assert property (p_no_zero) else $error("request at level zero");
    property p_trap_lvl; irq_req && irq_vector < 7'h04 |-> irq_level == {2'b10, irq_vector[1:0]}; endproperty
    a_trap_lvl: assert property (p_trap_lvl) else $error("trap level wrong");
    property p_user_lvl; irq_req && irq_vector >= 7'h04 |-> irq_level <= 4'h7 && irq_vector < 7'h0f; endproperty
    a_user_lvl: assert property (p_user_lvl) else $error("user request coding wrong");
    property p_take; irq_ack && irq_req |=> cpu_level == $past(irq_level); endproperty
    a_take: assert property (p_take) else $error("cpu level not taken");
    property p_timed_irq_disable_instr; $rose(timed_disable) |-> ##2 (!irq_req || irq_level >= 4'h7) [*8]; endproperty
    a_timed_irq_disable_instr: assert property (p_timed_irq_disable_instr) else $error("low level during timed disable");
endmodule : interrupt_priority_control_sva
bind interrupt_priority_control interrupt_priority_control_sva u_sva (.clk(clk), .sys_rst(sys_rst),
    .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .irq_ack(irq_ack), .timed_disable(timed_disable), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector(irq_vector), .cpu_level(cpu_level));

// ---- tb/irq_cpu_model.sv ----
`timescale 1ns/1ps
// CPU side: takes a request, services it, then returns
module irq_cpu_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       irq_req,
    input  wire logic       go,
    input  wire logic [3:0] svc,
    output logic            irq_ack,
    output logic            irq_return
);
    logic       busy; // Inside a service routine
    logic [3:0] cnt;  // Service cycles left
    // Ack pulse, wait, return pulse; stale requests ignored while busy
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {irq_ack, irq_return, busy, cnt} <= '0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            if (!busy && go && irq_req && !irq_ack && !irq_return) begin
                irq_ack <= 1'b1;
                busy <= 1'b1;
                cnt <= svc;
            end else if (busy && cnt == 4'h0) begin
                irq_return <= 1'b1;
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule : irq_cpu_model

// ---- tb/interrupt_priority_control_tb.sv ----
`timescale 1ns/1ps
// Drives the bus and sources; the cpu model answers requests
module interrupt_priority_control_tb;
    import irq_prio_pkg::*;
    logic        clk = 0, sys_rst = 1, hwrite = 0, hsel = 0, timed_disable = 0, go = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h2a;
    logic [1:0]  htrans = 0;
    logic [10:0] src_event = 0;
    logic [3:0]  trap_event = 0, irq_level, cpu_level, svc = 4'h3;
    logic [6:0]  irq_vector;
    logic        hreadyout, hresp, irq_ack, irq_return, irq_req, irq_out;
    int          errors = 0, total_checks = 0, acks = 0;
    int          ri[11] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3}; // Register of each source
    int          lb[11] = '{crc_err_lsb, serial2_err_lsb, serial1_err_lsb, can_tx_lsb, dma7_lsb, dma6_lsb,
                            encoder2_lsb, pwm2_fault_lsb, pwm2_lsb, dac_left_lsb, dac_right_lsb};
    logic [15:0] msk[4] = '{prio16_mask, prio17_mask, prio18_mask, prio19_mask};
    logic [15:0] rst[4] = '{prio16_rst, prio17_rst, prio18_rst, prio19_rst};
    always #25 clk = ~clk;
    always @(posedge clk) if (irq_ack) acks++;
    interrupt_priority_control u_interrupt_priority_control (.clk(clk), .sys_rst(sys_rst), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event), .trap_event(trap_event),
        .irq_ack(irq_ack), .irq_return(irq_return), .timed_disable(timed_disable), .irq_req(irq_req),
        .irq_level(irq_level), .irq_vector(irq_vector), .cpu_level(cpu_level), .irq_out(irq_out));
    irq_cpu_model u_irq_cpu_model (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req), .go(go), .svc(svc),
        .irq_ack(irq_ack), .irq_return(irq_return));
    // Next random value
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic print_verdict;
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            errors++;
        end
    endtask : chk
    // One single transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {haddr, hwrite, htrans, hsel} <= {24'h0, a, w, 2'b10, 1'b1};
        do begin @(posedge clk); n++; end while (!hreadyout && n < 40);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (!hreadyout && n < 40);
        rd = hrdata;
        if (n >= 40) begin errors++; print_verdict(); end
    endtask : bus
    // Only source i at level p, all other fields off
    task automatic setp(input int i, input logic [2:0] p);
        for (int k = 0; k < 4; k++) bus(1'b1, 8'(4 * k), k == ri[i] ? 32'(p) << lb[i] : 32'h0);
    endtask : setp
    task automatic ev(input logic [10:0] m);
        src_event <= m;
        @(posedge clk);
        src_event <= '0;
    endtask : ev
    // Bounded wait for a request
    task automatic wait_req(input int n);
        repeat (n) begin @(posedge clk); if (irq_req === 1'b1) return; end
        errors++;
        print_verdict();
    endtask : wait_req
    task automatic idle_chk(input int n);
        repeat (n) @(posedge clk);
        chk("irq_req", 0, irq_req);
    endtask : idle_chk
    initial begin repeat (20000) @(posedge clk); errors++; print_verdict(); end
    initial begin
        logic [2:0] p;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values, write masks, status and unmapped place
        for (int k = 0; k < 4; k++) begin
            bus(0, 8'(4 * k), 0);
            chk("prio_rst", {16'h0, rst[k]}, rd);
            bus(1, 8'(4 * k), 32'hffffffff);
            bus(0, 8'(4 * k), 0);
            chk("prio_mask", {16'h0, msk[k]}, rd);
        end
        for (int j = 0; j < 2; j++) begin
            bus(1, j ? 8'h30 : level_vec_off, 32'hffffffff);
            bus(0, j ? 8'h30 : level_vec_off, 0);
            chk("ro_place", 0, rd);
        end
        // Each source at a random level, gated by its enable
        for (int i = 0; i < num_src; i++) begin
            p = 3'(seed % 7 + 1);
            seed = xs(seed);
            setp(i, p);
            ev(11'(1 << i));
            idle_chk(4);
            bus(1, enable_off, 32'(1 << i));
            wait_req(20);
            chk("vector", 32'(4 + i), irq_vector);
            chk("level", p, irq_level);
            bus(1, flag_off, 0);
            bus(1, enable_off, 0);
            idle_chk(3);
        end
        // Equal levels everywhere: lowest vector wins
        for (int k = 0; k < 4; k++) bus(1, 8'(4 * k), 32'h3333);
        bus(1, enable_off, 32'h7ff);
        ev(11'h024);
        wait_req(20);
        chk("tie_vector", 32'h6, irq_vector);
        bus(1, flag_off, 0);
        bus(1, prio16_off, 0);
        ev(11'h001);
        idle_chk(4);
        // Level 7 blocks user sources but never traps
        bus(1, cpu_ctrl_off, 32'h7);
        bus(1, prio17_off, 32'h0777);
        ev(11'h010);
        idle_chk(4);
        trap_event <= 4'h4;
        @(posedge clk);
        trap_event <= 4'h0;
        wait_req(20);
        chk("trap", 32'ha02, {irq_level, 1'b0, irq_vector});
        repeat (4) @(posedge clk);
        chk("trap_hold", 1, irq_req);
        {hwdata} <= 0;
        bus(1, control_one_off, 0);
        bus(1, flag_off, 0);
        bus(1, cpu_ctrl_off, 0);
        // Timed disable holds level 6 back, level 7 passes
        bus(1, prio17_off, 32'h0670);
        timed_disable <= 1'b1;
        @(posedge clk);
        timed_disable <= 1'b0;
        ev(11'h008);
        idle_chk(8);
        ev(11'h010);
        wait_req(5);
        chk("timed_irq_disable_instr_pass", 32'h8, irq_vector);
        bus(1, flag_off, 32'h8);
        repeat (25) @(posedge clk);
        chk("timed_irq_disable_instr_end", 32'h607, {irq_level, 1'b0, irq_vector});
        // Cpu takes and returns; flag left set means retake
        bus(1, evt_enable_off, 32'h3);
        acks = 0;
        go <= 1'b1;
        repeat (40) @(posedge clk);
        chk("retake", 1, acks >= 2);
        chk("irq_out", 1, irq_out);
        go <= 1'b0;
        bus(1, flag_off, 0);
        repeat (10) @(posedge clk);
        chk("cpu_level", 0, cpu_level);
        bus(0, evt_status_off, 0);
        chk("evt_status", 32'h3, rd);
        bus(1, evt_enable_off, 0);
        @(posedge clk);
        chk("irq_masked", 0, irq_out);
        bus(1, evt_clear_off, 32'h3);
        bus(0, evt_status_off, 0);
        chk("evt_clear", 0, rd);
        // Nesting disable holds a level 7 source back during a service
        bus(1, control_one_off, 32'h8000);
        bus(1, flag_off, 32'h8);
        svc <= 4'hf;
        go <= 1'b1;
        repeat (4) @(posedge clk);
        go <= 1'b0;
        bus(1, flag_off, 32'h18);
        idle_chk(4);
        chk("nest_level", 6, cpu_level);
        bus(1, control_one_off, 0);
        wait_req(8);
        chk("nest_off", 32'h708, {irq_level, 1'b0, irq_vector});
        print_verdict();
    end
endmodule : interrupt_priority_control_tb
